// >>> ras_slave.sv
// Two-wire slave giving a bus master access to internal registers
// Contract
// - First byte after address in a write loads the register pointer.
// - STOP right after the pointer byte changes no register.
// - STOP resets the register pointer to zero.
// - Repeated START keeps the register pointer.
// - First data byte goes to the register the pointer selects.
// - Further written bytes go to successive registers.
// - Reads return the register the stored pointer selects.
// - Pointer advances after every byte read.
// - Device watches for START plus its seven-bit address, acknowledges match.
// - Ninth clock is acknowledge; receiver holds data low.
// - Direction bit low means write, high means read.
`include "ras_defs.svh"
module ras_slave
import ras_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `RAS_SLAVE_ADDR
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic wrValid,
    input wire logic wrReady,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    output logic [7:0] rdAddr,
    input wire logic [7:0] rdData,
    output logic busBusy
);
    logic sclMeta_r;
    logic sclSync_r;
    logic sclPrev_r;
    logic sdaMeta_r;
    logic sdaSync_r;
    logic sdaPrev_r;
    ras_state_t state_r;
    ras_state_t state_nxt;
    logic [7:0] shift_r;
    logic [3:0] bitCnt_r;
    logic [7:0] ptr_r;
    logic havePtr_r;
    logic isRead_r;
    logic ackOk_r;
    logic sdaOe_r;
    logic busBusy_r;
    logic bufReady;
    logic [15:0] bufOut;
    logic outValid;

    wire sclRise = sclSync_r && !sclPrev_r;
    wire sclFall = !sclSync_r && sclPrev_r;
    wire startSeen = sclSync_r && sclPrev_r && sdaPrev_r && !sdaSync_r;
    wire stopSeen = sclSync_r && sclPrev_r && !sdaPrev_r && sdaSync_r;
    wire [7:0] shiftNext = {shift_r[6:0], sdaSync_r};
    // Counter counts SCL rises: 7 before the last data rise, 8 until the fall that opens the ninth bit
    wire lastBit = (bitCnt_r == `RAS_BITS_PER_BYTE - 4'h1);
    wire byteDone = (bitCnt_r == `RAS_BITS_PER_BYTE);
    wire countRise = sclRise && (state_r == RAS_ADDR || state_r == RAS_RX || state_r == RAS_TX);
    wire byteEnd = sclFall && byteDone;
    wire addrMatch = (shiftNext[7:1] == SLAVE_ADDR);
    wire [7:0] ptrInc = ptr_r + 8'h01;
    // A write byte is only pushed when the buffer has room; a full buffer drops the ACK
    wire dataPush = (state_r == RAS_RX) && sclRise && lastBit && havePtr_r;
    // The pointer byte is always taken; a data byte only when the buffer can hold it
    wire rxAccept = !havePtr_r || bufReady;
    wire [2:0] txBit = 3'h7 - bitCnt_r[2:0];

    // Both lines cross into sys_clk through two flops before any use
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sclMeta_r <= 1'b1;
            sclSync_r <= 1'b1;
            sclPrev_r <= 1'b1;
            sdaMeta_r <= 1'b1;
            sdaSync_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end
        else
        begin
            sclMeta_r <= sclIn;
            sclSync_r <= sclMeta_r;
            sclPrev_r <= sclSync_r;
            sdaMeta_r <= sdaIn;
            sdaSync_r <= sdaMeta_r;
            sdaPrev_r <= sdaSync_r;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            RAS_IDLE:
                state_nxt = RAS_IDLE;
            RAS_ADDR:
                if (sclRise && lastBit && !addrMatch)
                    state_nxt = RAS_IDLE;
                else if (byteEnd)
                    state_nxt = RAS_ACK;
            RAS_RX:
                if (byteEnd)
                    state_nxt = RAS_ACK;
            RAS_ACK:
                if (sclFall)
                    state_nxt = isRead_r ? RAS_TX : RAS_RX;
            RAS_TX:
                if (byteEnd)
                    state_nxt = RAS_MACK;
            RAS_MACK:
                if (sclRise)
                    state_nxt = sdaSync_r ? RAS_IDLE : RAS_TX;
        endcase
        if (startSeen)
            state_nxt = RAS_ADDR;
        else if (stopSeen)
            state_nxt = RAS_IDLE;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= RAS_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            ptr_r <= `RAS_PTR_RESET;
            havePtr_r <= 1'b0;
            isRead_r <= 1'b0;
            ackOk_r <= 1'b0;
            busBusy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (startSeen)
            begin
                // Pointer survives a repeated START
                bitCnt_r <= 4'h0;
                havePtr_r <= 1'b0;
                busBusy_r <= 1'b1;
            end
            else if (stopSeen)
            begin
                // Pointer loaded without data is discarded here too
                ptr_r <= `RAS_PTR_RESET;
                busBusy_r <= 1'b0;
            end
            else
            begin
                if (countRise)
                    bitCnt_r <= bitCnt_r + 4'h1;
                if (byteEnd)
                    bitCnt_r <= 4'h0;
                if ((state_r == RAS_ADDR || state_r == RAS_RX) && sclRise)
                    shift_r <= shiftNext;
                if (state_r == RAS_ADDR && sclRise && lastBit)
                begin
                    isRead_r <= shiftNext[0] != `RAS_DIR_WRITE;
                    ackOk_r <= addrMatch;
                end
                if (state_r == RAS_RX && sclRise && lastBit)
                begin
                    ackOk_r <= rxAccept;
                    if (!havePtr_r)
                    begin
                        ptr_r <= shiftNext;
                        havePtr_r <= 1'b1;
                    end
                    else if (bufReady)
                        ptr_r <= ptrInc;
                end
                // A finished read byte moves the pointer on, acknowledged or not
                if (state_r == RAS_MACK && sclRise)
                    ptr_r <= ptrInc;
            end
        end
    end

    // Drive changes only after an SCL fall (and is dropped at START/STOP), so no false START/STOP is made
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            sdaOe_r <= 1'b0;
        else if (startSeen || stopSeen)
            sdaOe_r <= 1'b0;
        else if (sclFall)
        begin
            if (state_nxt == RAS_ACK)
                sdaOe_r <= ackOk_r;
            else if (state_nxt == RAS_TX)
                sdaOe_r <= !rdData[txBit];
            else
                sdaOe_r <= 1'b0;
        end
    end

    // Open drain: the pin is only ever pulled low, never driven high
    always_comb
    begin
        sdaOe = sdaOe_r;
        sdaOut = 1'b0;
    end

    ras_buf2 #(
        .WIDTH(16)
    ) u_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .inValid(dataPush),
        .inReady(bufReady),
        .inData({ptr_r, shiftNext}),
        .outValid(outValid),
        .outReady(wrReady),
        .outData(bufOut)
    );

    assign wrValid = outValid;
    assign wrAddr = bufOut[15:8];
    assign wrData = bufOut[7:0];
    assign rdAddr = ptr_r;
    assign busBusy = busBusy_r;
endmodule : ras_slave

// >>> ras_defs.svh
// Constants of the two-wire register access slave
`ifndef RAS_DEFS_SVH
`define RAS_DEFS_SVH
`define RAS_SLAVE_ADDR 7'h4C
`define RAS_PTR_RESET 8'h00
`define RAS_DIR_WRITE 1'b0
`define RAS_BITS_PER_BYTE 4'h8
`define RAS_BUF_DEPTH 2
`endif

// >>> ras_pkg.sv
// Types of the two-wire register access slave
package ras_pkg;
    typedef enum logic [2:0] {
        RAS_IDLE,
        RAS_ADDR,
        RAS_ACK,
        RAS_RX,
        RAS_TX,
        RAS_MACK
    } ras_state_t;
endpackage : ras_pkg

// >>> ras_buf2.sv
// Two-entry valid/ready buffer
module ras_buf2 #(
    parameter int WIDTH = 16
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_r [2];
    logic wrIdx_r;
    logic rdIdx_r;
    logic [1:0] count_r;
    logic outValid_r;
    logic [WIDTH-1:0] outData_r;
    wire doPush = inValid && inReady;
    wire doPop = outValid_r && outReady;
    wire [1:0] countNxt = count_r + {1'b0, doPush} - {1'b0, doPop};
    // Head copy kept in its own flops so outValid and outData come straight from registers
    wire headIsNew = (count_r == {1'b0, doPop});
    wire [WIDTH-1:0] headNxt = headIsNew ? inData : mem_r[rdIdx_r ^ doPop];

    assign inReady = (count_r != 2'h2);
    assign outValid = outValid_r;
    assign outData = outData_r;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wrIdx_r <= 1'b0;
            rdIdx_r <= 1'b0;
            count_r <= 2'h0;
            outValid_r <= 1'b0;
            outData_r <= '0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end
        else
        begin
            if (doPush)
            begin
                mem_r[wrIdx_r] <= inData;
                wrIdx_r <= ~wrIdx_r;
            end
            if (doPop)
                rdIdx_r <= ~rdIdx_r;
            count_r <= countNxt;
            outValid_r <= (countNxt != 2'h0);
            outData_r <= headNxt;
        end
    end
endmodule : ras_buf2

// >>> ras_monitor.sv
// Port-level assertions for the two-wire register access slave
module ras_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic wrValid,
    input wire logic wrReady,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdAddr,
    input wire logic [7:0] rdData,
    input wire logic busBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence startSeen;
        sclIn && $fell(sdaIn) ##1 sclIn;
    endsequence
    sequence stopSeen;
        sclIn && $rose(sdaIn) ##1 sclIn;
    endsequence
    start_busy_a: assert property (startSeen |-> ##[0:4] busBusy) else $error("no busy after start");
    stop_idle_a: assert property (stopSeen |-> ##[0:4] !busBusy) else $error("busy after stop");
    idle_ptr_a: assert property (!busBusy && !$past(busBusy, 3) |-> rdAddr == 8'h00) else $error("ptr not zero");
    idle_quiet_a: assert property (!busBusy |-> !sdaOe) else $error("data driven while idle");
    open_drain_a: assert property (sdaOe |-> sdaOut == 1'b0) else $error("data driven high");
    oe_edge_a: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved in clock high");
    oe_stand_a: assert property ($rose(sdaOe) |-> sdaOe[*4]) else $error("data bit too short");
    wr_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrData}))
        else $error("write word lost");
endmodule : ras_monitor
bind ras_slave ras_monitor i_ras_monitor (.sys_clk(sys_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData),
    .rdAddr(rdAddr), .rdData(rdData), .busBusy(busBusy));

// >>> ras_master.sv
// Behavioural two-wire bus master
module ras_master (
    output logic scl,
    output logic sdaDrv,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines rest high between frames: scl is driven high and sdaDrv is released to one
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task start;
        sdaDrv = 1'b1;
        #80 scl = 1'b1;
        #80 sdaDrv = 1'b0;
        #80 scl = 1'b0;
        #80;
    endtask : start
    task stop;
        sdaDrv = 1'b0;
        #80 scl = 1'b1;
        #80 sdaDrv = 1'b1;
        #160;
    endtask : stop
    task clk_bit(input logic o, output logic i);
        sdaDrv = o;
        #80 scl = 1'b1;
        #80 i = sda;
        #80 scl = 1'b0;
        #80;
    endtask : clk_bit
    task xfer(input logic [7:0] o, input logic ackIn, output logic [7:0] i, output logic ackOut);
        for (int k = 7; k >= 0; k--)
            clk_bit(o[k], i[k]);
        clk_bit(ackIn, ackOut);
    endtask : xfer
endmodule : ras_master

// >>> tb.sv
// Self-checking bench for the two-wire register access slave
`include "ras_defs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] AW = {`RAS_SLAVE_ADDR, `RAS_DIR_WRITE};
    localparam logic [7:0] AR = {`RAS_SLAVE_ADDR, 1'b1};
    logic sys_clk = 1'b0, reset = 1'b1, wrReady = 1'b0, sdaOut, sdaOe, wrValid, busBusy, scl, sdaDrv, ack;
    logic [7:0] wrAddr, wrData, rdAddr, rx;
    logic [7:0] regs [256];
    int fail_count = 0, n_compared = 0, nWr = 0, cyc = 0, n0;
    wire logic sda = sdaDrv & ~(sdaOe & ~sdaOut);
    always #20 sys_clk = ~sys_clk;
    ras_slave i_ras_slave (.sys_clk(sys_clk), .reset(reset), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData),
        .rdAddr(rdAddr), .rdData(regs[rdAddr]), .busBusy(busBusy));
    ras_master i_ras_master (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));
    always @(posedge sys_clk)
    begin
        cyc++;
        if (wrValid && wrReady)
        begin
            regs[wrAddr] <= wrData;
            nWr++;
        end
        if (cyc > 8000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task go;
        @(posedge sys_clk);
        #1;
    endtask : go
    task wb(input logic [7:0] b, input logic expAck);
        i_ras_master.xfer(b, 1'b1, rx, ack);
        `CHK("ack", expAck, ack)
    endtask : wb
    task rb(input logic [7:0] e, input logic last);
        i_ras_master.xfer(8'hFF, last, rx, ack);
        `CHK("read", e, rx)
    endtask : rb
    task finish_frame(input string name);
        i_ras_master.stop();
        repeat (8) go();
        `CHK("ptr", 8'h00, rdAddr)
        $display("%s done", name);
    endtask : finish_frame
    task t_write;
        go();
        i_ras_master.start();
        wb(AW, 1'b0);
        wb(8'h05, 1'b0);
        wb(8'hAA, 1'b0);
        wb(8'h55, 1'b0);
        finish_frame("write");
        `CHK("reg05", 8'hAA, regs[5])
        `CHK("reg06", 8'h55, regs[6])
    endtask : t_write
    task t_ptronly;
        n0 = nWr;
        go();
        i_ras_master.start();
        wb(AW, 1'b0);
        wb(8'h10, 1'b0);
        `CHK("load", 8'h10, rdAddr)
        finish_frame("pointer only");
        `CHK("writes", n0, nWr)
    endtask : t_ptronly
    task t_read;
        go();
        i_ras_master.start();
        wb(AW, 1'b0);
        wb(8'h05, 1'b0);
        i_ras_master.start();
        wb(AR, 1'b0);
        rb(8'hAA, 1'b0);
        rb(8'h55, 1'b1);
        finish_frame("read");
        `CHK("release", 1'b0, sdaOe)
    endtask : t_read
    task t_wrong;
        go();
        i_ras_master.start();
        wb(AW ^ 8'h02, 1'b1);
        finish_frame("foreign address");
    endtask : t_wrong
    // A stalled register file fills the two-entry buffer; the third byte must be refused
    task t_stall;
        go();
        wrReady = 1'b0;
        i_ras_master.start();
        wb(AW, 1'b0);
        wb(8'hFF, 1'b0);
        wb(8'h11, 1'b0);
        wb(8'h22, 1'b0);
        wb(8'h33, 1'b1);
        `CHK("held", 1'b1, wrValid)
        go();
        wrReady = 1'b1;
        finish_frame("stall");
        `CHK("regFF", 8'h11, regs[255])
        `CHK("reg00", 8'h22, regs[0])
        `CHK("reg01", 8'h00, regs[1])
    endtask : t_stall
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial
    begin
        foreach (regs[k])
            regs[k] = 8'h00;
        repeat (12) go();
        reset = 1'b0;
        wrReady = 1'b1;
        repeat (4) go();
        t_write();
        t_ptronly();
        t_read();
        t_wrong();
        t_stall();
        end_sim();
    end
endmodule : tb
